// File: rtl/tdp_pkg.sv
// ****************************************************************
// Shared constants of the drive and shutdown register slice
// ****************************************************************
package tdp_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W   = 8;                // Register port address width
  localparam int DATA_W   = 8;                // Register width
  localparam int FIELD_W  = 4;                // One lane drive code width
  localparam int NUM_REGS = 5;                // Registers held by this slice
  localparam int INDEX_W  = 3;                // Width of a register index

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_DRIVE_CODE_BANK2_CH23         = 8'h1b;
  localparam logic [7:0] ADDR_DRIVE_CODE_BANK3_CH01         = 8'h1c;
  localparam logic [7:0] ADDR_DRIVE_CODE_BANK3_CH23         = 8'h1d;
  localparam logic [7:0] ADDR_TRANSMITTER_SHUTDOWN_BANKS01  = 8'h1e;
  localparam logic [7:0] ADDR_TRANSMITTER_SHUTDOWN_BANKS23  = 8'h1f;

  // ****************************************************************
  // Register indexes in the bank
  // ****************************************************************
  localparam logic [2:0] IDX_DRIVE_BANK2_CH23    = 3'h0;
  localparam logic [2:0] IDX_DRIVE_BANK3_CH01    = 3'h1;
  localparam logic [2:0] IDX_DRIVE_BANK3_CH23    = 3'h2;
  localparam logic [2:0] IDX_SHUTDOWN_BANKS01    = 3'h3;
  localparam logic [2:0] IDX_SHUTDOWN_BANKS23    = 3'h4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LOW_LANE_LSB   = 0;          // Even channel drive code
  localparam int HIGH_LANE_LSB  = 4;          // Odd channel drive code
  localparam int LOW_BANK_LSB   = 0;          // Shutdown bits of lower bank
  localparam int HIGH_BANK_LSB  = 4;          // Shutdown bits of upper bank

  // ****************************************************************
  // Reset values and code range
  // ****************************************************************
  localparam logic [3:0] DRIVE_CODE_RESET = 4'h8;      // Only the top bit set
  localparam logic [7:0] DRIVE_REG_RESET  = 8'h88;     // Two lanes at mid drive
  localparam logic [7:0] SHUTDOWN_RESET   = 8'h00;     // All transmitters on
  localparam logic [3:0] DRIVE_CODE_MIN   = 4'h0;      // Smallest swing
  localparam logic [3:0] DRIVE_CODE_MAX   = 4'hf;      // Largest swing
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;     // Answer to a foreign offset

  // Reset value of each register, by index
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET =
    {SHUTDOWN_RESET, SHUTDOWN_RESET, DRIVE_REG_RESET, DRIVE_REG_RESET, DRIVE_REG_RESET};

endpackage

// File: rtl/tdp_cfg_byte.sv
`timescale 1ns/1ps
// ****************************************************************
// One writable configuration byte with its own reset value
// ****************************************************************
module tdp_cfg_byte
#(
  parameter logic [7:0] RESET_VALUE = 8'h00  // Value after reset
)
(
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       wr_en,
  input  wire logic [tdp_pkg::DATA_W-1:0] wr_data,
  output logic      [tdp_pkg::DATA_W-1:0] value
);
  import tdp_pkg::*;

  // State of the byte
  typedef struct packed
  {
    logic [DATA_W-1:0] value;                 // Stored setting
  } tdp_byte_state_type;

  tdp_byte_state_type state;                  // Registered state
  tdp_byte_state_type next_state;             // Next state

  // ****************************************************************
  // Next value
  // ****************************************************************
  // Store the written byte, hold otherwise
  always_comb
  begin
    next_state = state;
    if (wr_en)
    begin
      next_state.value = wr_data;             // Whole byte, no clamping
    end
  end

  // Register the state
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state.value <= RESET_VALUE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign value = state.value;                 // Straight from the flop

endmodule

// File: rtl/tdp_regs.sv
`timescale 1ns/1ps
// Operation
// - 0x1B: bank2 ch2 low nibble, ch3 high
// - 0x1C: bank3 ch0 low nibble, ch1 high
// - 0x1D: bank3 ch2 low nibble, ch3 high
// - Drive codes reset to 1000, register 0x88
// - Codes 0 to 15, larger means stronger
// - 0x1E: shutdown bits banks 0 and 1
// - 0x1F: shutdown bits banks 2 and 3
// - Shutdown bits reset to zero
// - Registers reached through the parallel register port
// - Shutdown bit one turns transmitter off
module tdp_regs
(
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [tdp_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [tdp_pkg::DATA_W-1:0] reg_wdata,
  output logic      [tdp_pkg::DATA_W-1:0] reg_rdata,
  output logic                            reg_rvalid,
  output logic                            reg_hit,
  output logic      [tdp_pkg::FIELD_W-1:0] drive_code_bank2_ch2,
  output logic      [tdp_pkg::FIELD_W-1:0] drive_code_bank2_ch3,
  output logic      [tdp_pkg::FIELD_W-1:0] drive_code_bank3_ch0,
  output logic      [tdp_pkg::FIELD_W-1:0] drive_code_bank3_ch1,
  output logic      [tdp_pkg::FIELD_W-1:0] drive_code_bank3_ch2,
  output logic      [tdp_pkg::FIELD_W-1:0] drive_code_bank3_ch3,
  output logic      [tdp_pkg::DATA_W-1:0] transmitter_shutdown_lower_banks,
  output logic      [tdp_pkg::DATA_W-1:0] transmitter_shutdown_upper_banks
);
  import tdp_pkg::*;

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  // True when the offset belongs to this slice
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    addr_hit = (addr >= ADDR_DRIVE_CODE_BANK2_CH23) &&
               (addr <= ADDR_TRANSMITTER_SHUTDOWN_BANKS23);
  endfunction

  // Index of the register at an offset, zero when foreign
  function automatic logic [INDEX_W-1:0] addr_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] diff;
    diff = addr - ADDR_DRIVE_CODE_BANK2_CH23;
    if (addr_hit(addr))
    begin
      addr_index = diff[INDEX_W-1:0];
    end
    else
    begin
      addr_index = '0;
    end
  endfunction

  // ****************************************************************
  // Register bank
  // ****************************************************************
  logic [DATA_W-1:0]   reg_value [NUM_REGS];  // Current register contents
  logic [NUM_REGS-1:0] reg_write;             // Per register write strobe
  logic                wr_hit;                // Write lands in this slice
  logic [INDEX_W-1:0]  wr_index;              // Register being written

  assign wr_hit   = reg_wr && addr_hit(reg_addr);
  assign wr_index = addr_index(reg_addr);

  // One byte per offset, each with its own reset value
  genvar i;
  generate
    for (i = 0; i < NUM_REGS; i++)
    begin : g_reg
      assign reg_write[i] = wr_hit && (wr_index == INDEX_W'(i));
      tdp_cfg_byte
      #(
        .RESET_VALUE (REG_RESET[i])
      )
      u_byte
      (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .wr_en   (reg_write[i]),
        .wr_data (reg_wdata),
        .value   (reg_value[i])
      );
    end
  endgenerate

  // ****************************************************************
  // Lane controls, straight from the register flops
  // ****************************************************************
  // Full four-bit code is passed on, 0 weakest and 15 strongest
  assign drive_code_bank2_ch2 =
    reg_value[IDX_DRIVE_BANK2_CH23][LOW_LANE_LSB +: FIELD_W];
  assign drive_code_bank2_ch3 =
    reg_value[IDX_DRIVE_BANK2_CH23][HIGH_LANE_LSB +: FIELD_W];
  assign drive_code_bank3_ch0 =
    reg_value[IDX_DRIVE_BANK3_CH01][LOW_LANE_LSB +: FIELD_W];
  assign drive_code_bank3_ch1 =
    reg_value[IDX_DRIVE_BANK3_CH01][HIGH_LANE_LSB +: FIELD_W];
  assign drive_code_bank3_ch2 =
    reg_value[IDX_DRIVE_BANK3_CH23][LOW_LANE_LSB +: FIELD_W];
  assign drive_code_bank3_ch3 =
    reg_value[IDX_DRIVE_BANK3_CH23][HIGH_LANE_LSB +: FIELD_W];

  // A one bit shuts that lane's transmitter off
  assign transmitter_shutdown_lower_banks = reg_value[IDX_SHUTDOWN_BANKS01];
  assign transmitter_shutdown_upper_banks = reg_value[IDX_SHUTDOWN_BANKS23];

  // ****************************************************************
  // Read answer
  // ****************************************************************
  // State of the read side
  typedef struct packed
  {
    logic [DATA_W-1:0] rdata;                 // Read data
    logic              rvalid;                // Read answer strobe
    logic              hit;                   // Read offset was ours
  } tdp_read_state_type;

  tdp_read_state_type state;                  // Registered state
  tdp_read_state_type next_state;             // Next state

  // Answer a read one cycle later, old value on same cycle write
  always_comb
  begin
    next_state        = state;
    next_state.rvalid = reg_rd;
    next_state.hit    = reg_rd && addr_hit(reg_addr);
    if (reg_rd && addr_hit(reg_addr))
    begin
      next_state.rdata = reg_value[addr_index(reg_addr)];
    end
    else if (reg_rd)
    begin
      next_state.rdata = UNMAPPED_READ;       // Foreign offset
    end
  end

  // Register the read state
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state.rdata  <= UNMAPPED_READ;
      state.rvalid <= 1'b0;
      state.hit    <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata  = state.rdata;
  assign reg_rvalid = state.rvalid;
  assign reg_hit    = state.hit;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Write to a given offset
  sequence wr_at(logic [7:0] a);
    reg_wr && (reg_addr == a);
  endsequence

  // Read of the same offset in the next cycle
  sequence rd_next(logic [7:0] a);
    ##1 (reg_rd && !reg_wr && (reg_addr == a));
  endsequence

  drive_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    sys_rst |=> (reg_value[IDX_DRIVE_BANK2_CH23] == 8'h88) &&
                (reg_value[IDX_DRIVE_BANK3_CH01] == 8'h88) &&
                (reg_value[IDX_DRIVE_BANK3_CH23] == 8'h88))
    else $error("drive code not 0x88 after reset");

  shutdown_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    sys_rst |=> (transmitter_shutdown_lower_banks == 8'h00) &&
                (transmitter_shutdown_upper_banks == 8'h00))
    else $error("shutdown bits not zero after reset");

  bank2_field_a: assert property (wr_at(8'h1b) |=>
    (drive_code_bank2_ch2 == $past(reg_wdata[3:0])) &&
    (drive_code_bank2_ch3 == $past(reg_wdata[7:4])))
    else $error("bank2 drive fields misplaced");

  bank3_low_a: assert property (wr_at(8'h1c) |=>
    (drive_code_bank3_ch0 == $past(reg_wdata[3:0])) &&
    (drive_code_bank3_ch1 == $past(reg_wdata[7:4])))
    else $error("bank3 ch0/1 drive fields misplaced");

  bank3_high_a: assert property (wr_at(8'h1d) |=>
    (drive_code_bank3_ch2 == $past(reg_wdata[3:0])) &&
    (drive_code_bank3_ch3 == $past(reg_wdata[7:4])))
    else $error("bank3 ch2/3 drive fields misplaced");

  lower_shutdown_a: assert property (wr_at(8'h1e) |=>
    transmitter_shutdown_lower_banks == $past(reg_wdata))
    else $error("lower bank shutdown not updated");

  upper_shutdown_a: assert property (wr_at(8'h1f) |=>
    transmitter_shutdown_upper_banks == $past(reg_wdata))
    else $error("upper bank shutdown not updated");

  foreign_write_a: assert property ((reg_wr && !addr_hit(reg_addr)) |=>
    $stable(reg_value[IDX_DRIVE_BANK2_CH23]) && $stable(reg_value[IDX_DRIVE_BANK3_CH01]) &&
    $stable(reg_value[IDX_DRIVE_BANK3_CH23]) && $stable(transmitter_shutdown_lower_banks) &&
    $stable(transmitter_shutdown_upper_banks))
    else $error("foreign offset changed a register");

  read_back_a: assert property (wr_at(8'h1d) ##0 rd_next(8'h1d) |=>
    reg_rvalid && reg_hit && (reg_rdata == $past(reg_wdata, 2)))
    else $error("read did not return last write");

  foreign_read_a: assert property ((reg_rd && !addr_hit(reg_addr)) |=>
    reg_rvalid && !reg_hit && (reg_rdata == 8'h00))
    else $error("foreign read not answered with zero");

  no_read_a: assert property (!reg_rd |=> !reg_rvalid && !reg_hit)
    else $error("answer strobe without read");

  // Settings hold while nothing lands in the slice
  hold_no_write_a: assert property (!wr_hit |=>
    $stable(reg_value[IDX_DRIVE_BANK2_CH23]) && $stable(reg_value[IDX_DRIVE_BANK3_CH01]) &&
    $stable(reg_value[IDX_DRIVE_BANK3_CH23]) && $stable(reg_value[IDX_SHUTDOWN_BANKS01]) &&
    $stable(reg_value[IDX_SHUTDOWN_BANKS23]))
    else $error("setting changed without a write");

endmodule

// File: bench/tdp_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Host model driving the parallel register port
// ****************************************************************
module tdp_host
  import tdp_pkg::*;
(
  input  wire logic                       sys_clk,
  output logic                            reg_wr,
  output logic                            reg_rd,
  output logic      [tdp_pkg::ADDR_W-1:0] reg_addr,
  output logic      [tdp_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [tdp_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       reg_rvalid,
  input  wire logic                       reg_hit
);
  // Port idle from time zero
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One request held a cycle, answer taken the cycle after
  task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, output logic [9:0] ans);
    @(negedge sys_clk);
    reg_wr    = w;
    reg_rd    = r;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge sys_clk);
    ans       = {reg_rvalid, reg_hit, reg_rdata};
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    // Released lines show no stale value
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // Write, then read the same offset in the very next cycle
  task automatic wr_then_rd(input logic [7:0] a, input logic [7:0] d,
                            output logic [9:0] ans);
    @(negedge sys_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    reg_wdata = ~d;
    @(negedge sys_clk);
    ans       = {reg_rvalid, reg_hit, reg_rdata};
    reg_rd    = 1'b0;
    reg_addr  = ~a;
  endtask
endmodule

// File: bench/tb_tx_drive_powerdown_regs.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the drive and shutdown slice
// ****************************************************************
module tb_tx_drive_powerdown_regs;
  import tdp_pkg::*;
  typedef struct packed
  {
    logic [7:0] addr;                  // Offset written then read
    logic [7:0] data;                  // Value written
    logic [7:0] exp_rdata;             // Value read back
    logic       exp_hit;               // Offset belongs here
  } tdp_row_type;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr, reg_rd, reg_rvalid, reg_hit;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  b2c2, b2c3, b3c0, b3c1, b3c2, b3c3;
  logic [7:0]  sd_lo, sd_hi;
  logic [39:0] lanes;                  // All lane controls in one word
  logic [7:0]  shadow [5];             // Expected register contents
  logic [9:0]  ans;                    // Valid, hit, data of last read
  int          err_count  = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  // Mapped offsets, both code extremes, then two foreign offsets
  tdp_row_type rows [7] = '{'{8'h1b, 8'ha5, 8'ha5, 1'b1}, '{8'h1c, 8'h0f, 8'h0f, 1'b1},
                            '{8'h1d, 8'hf0, 8'hf0, 1'b1}, '{8'h1e, 8'h5a, 8'h5a, 1'b1},
                            '{8'h1f, 8'ha5, 8'ha5, 1'b1}, '{8'h20, 8'hff, 8'h00, 1'b0},
                            '{8'h1a, 8'h33, 8'h00, 1'b0}};
  assign lanes = {sd_hi, sd_lo, b3c3, b3c2, b3c1, b3c0, b2c3, b2c2};

  // Clock, 100 ns period
  always #50 sys_clk = ~sys_clk;

  tdp_regs dut
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .drive_code_bank2_ch2(b2c2), .drive_code_bank2_ch3(b2c3),
    .drive_code_bank3_ch0(b3c0), .drive_code_bank3_ch1(b3c1),
    .drive_code_bank3_ch2(b3c2), .drive_code_bank3_ch3(b3c3),
    .transmitter_shutdown_lower_banks(sd_lo), .transmitter_shutdown_upper_banks(sd_hi)
  );
  tdp_host host
  (
    .sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_hit(reg_hit)
  );

  // Count, compare, report
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Read one offset and compare the answer
  task automatic rd(input logic [7:0] a, input logic h, input logic [7:0] d);
    host.xfer(1'b0, 1'b1, a, 8'h00, ans);
    chk("read", {30'h0, ans}, {30'h0, 1'b1, h, d});
  endtask

  // Restore expected contents to their reset values
  task automatic shadow_reset;
    for (int i = 0; i < 5; i++)
      shadow[i] = REG_RESET[i];
  endtask

  // Expected lane controls from the shadow contents
  function automatic logic [39:0] exp_lanes();
    return {shadow[4], shadow[3], shadow[2], shadow[1], shadow[0]};
  endfunction

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      err_count++;
      test_done();
    end
  end

  // Main sequence
  initial
  begin
    shadow_reset();
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    // Reset contents
    chk("reset lanes", lanes, exp_lanes());
    for (int i = 0; i < 5; i++)
      rd(ADDR_DRIVE_CODE_BANK2_CH23 + 8'(i), 1'b1, REG_RESET[i]);
    // Table of writes each read back
    foreach (rows[i])
    begin
      host.xfer(1'b1, 1'b0, rows[i].addr, rows[i].data, ans);
      if (rows[i].exp_hit)
        shadow[rows[i].addr - 8'h1b] = rows[i].data;
      chk("lanes", lanes, exp_lanes());
      rd(rows[i].addr, rows[i].exp_hit, rows[i].exp_rdata);
    end
    // Write then read next cycle: answer pulse, then data held
    host.wr_then_rd(8'h1d, 8'h7e, ans);
    shadow[2] = 8'h7e;
    chk("back to back read", {30'h0, ans}, {30'h0, 2'b11, 8'h7e});
    @(negedge sys_clk);
    chk("read data held", {30'h0, reg_rvalid, reg_hit, reg_rdata}, {32'h0, 8'h7e});
    chk("lanes back to back", lanes, exp_lanes());
    // Read and write together: old value first, new after
    host.xfer(1'b1, 1'b1, 8'h1c, 8'h3c, ans);
    chk("read with write", {30'h0, ans}, {30'h0, 2'b11, shadow[1]});
    shadow[1] = 8'h3c;
    rd(8'h1c, 1'b1, 8'h3c);
    chk("lanes after", lanes, exp_lanes());
    // Reset in mid-run
    @(negedge sys_clk);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    sys_rst = 1'b0;
    shadow_reset();
    chk("lanes rerun", lanes, exp_lanes());
    chk("read side reset", {30'h0, reg_rvalid, reg_hit, reg_rdata}, 40'h0);
    rd(8'h1f, 1'b1, SHUTDOWN_RESET);
    test_done();
  end
endmodule
